/* rtl/urad_pkg.sv */
// Purpose: Shared constants for the address-detecting serial receiver
// Assumes: Byte-wide register port, four-bit register index
// Notes:   Register indices are local choices; field positions follow the bit layouts
package urad_pkg;
  // Register indices
  localparam logic [3:0] ADDR_IRQ_FLAGS   = 4'h0;
  localparam logic [3:0] ADDR_IRQ_ENABLES = 4'h1;
  localparam logic [3:0] ADDR_IRQ_PRIO    = 4'h2;
  localparam logic [3:0] ADDR_RX_STATUS   = 4'h3;
  localparam logic [3:0] ADDR_RX_DATA     = 4'h4;
  localparam logic [3:0] ADDR_TX_STATUS   = 4'h5;
  localparam logic [3:0] ADDR_BAUD_CTRL   = 4'h6;
  localparam logic [3:0] ADDR_DIV_HIGH    = 4'h7;
  localparam logic [3:0] ADDR_DIV_LOW     = 4'h8;
  localparam logic [3:0] ADDR_EVT_STATUS  = 4'h9;
  localparam logic [3:0] ADDR_EVT_MASK    = 4'hA;
  // Receive status/control fields
  localparam int RS_SERIAL_PORT_ENABLE = 7;
  localparam int RS_RX9  = 6;
  localparam int RS_SREN = 5;
  localparam int RS_CONTINUOUS_RX_ENABLE = 4;
  localparam int RS_ADEN = 3;
  localparam int RS_FRAME_ERROR_FLAG = 2;
  localparam int RS_OVERRUN_FLAG = 1;
  localparam int RS_NINTH_RX_BIT = 0;
  // Writable bits of receive status/control
  localparam logic [7:0] RS_WMASK = 8'h_F8;
  // Pending flag, enable and priority position
  localparam int IRQ_RX_BIT = 5;
  // Implemented bits of enable and priority registers
  localparam logic [7:0] IRQ_WMASK = 8'h_7F;
  // Transmit status/control fields
  localparam int TS_SYNC = 4;
  localparam int TS_HIGH_SPEED_BAUD_SELECT = 2;
  localparam int TS_TRMT = 1;
  // Baud control fields
  localparam int BC_RCIDL = 6;
  localparam int BC_RX_POLARITY_INVERT = 5;
  localparam int BC_WIDE_DIVISOR_SELECT = 3;
  localparam logic [7:0] BC_WMASK = 8'h_3B;
  // Event status bits
  localparam int EV_CHAR  = 0;
  localparam int EV_OVR   = 1;
  localparam int EV_FRAME = 2;
  localparam int EV_W     = 3;
  // Oversampling, character lengths, buffer depth and zero byte
  localparam logic [4:0] TICKS_NORMAL = 5'h_10;
  localparam logic [4:0] TICKS_QUAD   = 5'h_04;
  localparam logic [1:0] PRESCALE_LOW = 2'h_3;
  localparam logic [3:0] BITS_EIGHT   = 4'h_8;
  localparam logic [3:0] BITS_NINE    = 4'h_9;
  localparam logic [1:0] FIFO_DEPTH   = 2'h_2;
  localparam logic [7:0] ZERO_BYTE    = 8'h_00;
  // Receiver states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_START = 4'b0010,
    ST_DATA  = 4'b0100,
    ST_STOP  = 4'b1000
  } urad_state_t;
endpackage

/* rtl/urad_baud_gen.sv */
// Purpose: Oversampling tick generator for the serial receiver
// Assumes: Divisor is stable while a character is in flight
// Notes:   Low-speed eight-bit mode adds a divide-by-four prescale
`timescale 1ns/100ps
`default_nettype none
module urad_baud_gen (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // Configuration
  input  wire logic        enable,
  input  wire logic [15:0] divisor,
  input  wire logic        wide,
  input  wire logic        high,
  // Oversample enable pulse
  output logic             tick
);
  logic [15:0] div_cnt;      // Counts divisor down
  logic [1:0]  pre_cnt;      // Prescale count
  logic [15:0] next_div_cnt;
  logic [1:0]  next_pre_cnt;
  logic        next_tick;
  logic [15:0] div_eff;      // Narrow mode uses low byte only
  logic        use_pre;

  // Next count and tick
  always_comb
  begin
    div_eff      = wide ? divisor : {8'h_00, divisor[7:0]};
    use_pre      = !wide && !high;
    next_div_cnt = div_cnt;
    next_pre_cnt = pre_cnt;
    next_tick    = 1'b0;
    if (!enable)
    begin
      next_div_cnt = div_eff;
      next_pre_cnt = 2'h_0;
    end
    else if (div_cnt != 16'h_0000)
      next_div_cnt = div_cnt - 16'h_0001;
    else
    begin
      // Reload; prescaler gates the pulse
      next_div_cnt = div_eff;
      if (!use_pre || pre_cnt == urad_pkg::PRESCALE_LOW)
      begin
        next_pre_cnt = 2'h_0;
        next_tick    = 1'b1;
      end
      else
        next_pre_cnt = pre_cnt + 2'h_1;
    end
  end

  // Register only
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      div_cnt <= 16'h_0000;
      pre_cnt <= 2'h_0;
      tick    <= 1'b0;
    end
    else
    begin
      div_cnt <= next_div_cnt;
      pre_cnt <= next_pre_cnt;
      tick    <= next_tick;
    end
  end
endmodule
`default_nettype wire

/* rtl/urad_rx.sv */
// Purpose: Asynchronous receiver with ninth-bit address filter and two-deep buffer
// Assumes: Register strobes are one cycle, read data follow one cycle later
// Notes:   Clearing the port enable resets buffer, flags and the receive machine
`timescale 1ns/100ps
`default_nettype none
//
// Contract
// - Filter mode follows the filter enable bit
// - Filtering keeps only ninth-bit-set characters
// - Pending flag set when character is buffered
// - Receive interrupt needs its enable bit
// - Filtered characters read back ninth bit one
// - Clearing receive enable clears overrun
// - Polarity bit inverts incoming line data
// - Bit rate from divisor and select bits
// - Unfiltered characters reach the buffer unless it is full or overrun is set
// - Two-deep buffer; third character sets overrun
// - Sixteen-times oversampling (four with wide divisor and high speed), mid-start check, majority
// - Ninth-bit field shows oldest character
// - Framing error per character, advanced by read
module urad_rx (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // Register port
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  output logic      [7:0] reg_rdata,
  // Serial line
  input  wire logic       rx_pin,
  // Interrupt outputs
  output logic            rx_irq,
  output logic            rx_irq_high_priority,
  output logic            irq
);
  // Software registers
  logic [7:0] rs_ctrl;        // Upper control bits of status/control
  logic [7:0] irq_enables;
  logic [7:0] irq_priority;
  logic [7:0] tx_ctrl;
  logic [7:0] baud_ctrl;
  logic [7:0] div_high;
  logic [7:0] div_low;
  logic [2:0] evt_status;     // Sticky, write one to clear
  logic [2:0] evt_mask;
  logic       overrun_flag;
  // Receive buffer: {frame error, nine data bits}
  logic [9:0] fifo_mem [2];
  logic       rd_ptr;
  logic       wr_ptr;
  logic [1:0] fifo_count;
  // Line path
  logic [2:0] pin_sync;       // Three-stage synchroniser
  logic       line_filt;      // Agreed level
  logic       line_level;     // After polarity
  // Receive machine
  urad_pkg::urad_state_t state;
  urad_pkg::urad_state_t next_state;
  logic [4:0] tick_cnt;
  logic [4:0] next_tick_cnt;
  logic [3:0] bit_idx;
  logic [3:0] next_bit_idx;
  logic [8:0] shreg;          // Receive shift register
  logic [8:0] next_shreg;
  logic [1:0] votes;
  logic [1:0] next_votes;
  logic       char_done;      // Stop bit decided this cycle
  logic       stop_bad;
  // Derived
  logic       tick;
  logic [4:0] tpb;
  logic       port_on;
  logic       rx_on;
  logic       voted;
  logic       discard;
  logic       push;
  logic       pop;
  logic       set_ovr;
  logic       pending;
  logic [9:0] top;
  // Next values of register group
  logic [7:0] next_rs_ctrl;
  logic       next_overrun;
  logic [2:0] next_evt_status;
  logic [1:0] next_fifo_count;
  logic [7:0] next_rdata;

  assign port_on = rs_ctrl[urad_pkg::RS_SERIAL_PORT_ENABLE];
  assign rx_on   = port_on && rs_ctrl[urad_pkg::RS_CONTINUOUS_RX_ENABLE] && !tx_ctrl[urad_pkg::TS_SYNC];
  // Quarter mode gives only four ticks per bit
  assign tpb     = (baud_ctrl[urad_pkg::BC_WIDE_DIVISOR_SELECT] && tx_ctrl[urad_pkg::TS_HIGH_SPEED_BAUD_SELECT])
                   ? urad_pkg::TICKS_QUAD : urad_pkg::TICKS_NORMAL;
  assign top     = fifo_mem[rd_ptr];
  assign pending = fifo_count != 2'h_0;
  assign voted   = (votes[1] & votes[0]) | (votes[1] & line_level)
                   | (votes[0] & line_level);
  assign line_level = line_filt ^ baud_ctrl[urad_pkg::BC_RX_POLARITY_INVERT];

  // Oversample tick source
  urad_baud_gen u_baud (
    .clock   (clock),
    .rst     (rst),
    .enable  (rx_on),
    .divisor ({div_high, div_low}),
    .wide    (baud_ctrl[urad_pkg::BC_WIDE_DIVISOR_SELECT]),
    .high    (tx_ctrl[urad_pkg::TS_HIGH_SPEED_BAUD_SELECT]),
    .tick    (tick)
  );

  // Pin synchroniser; level moves only when stages two and three agree
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      pin_sync  <= 3'h_7;
      line_filt <= 1'b1;
    end
    else
    begin
      pin_sync <= {pin_sync[1:0], rx_pin};
      if (pin_sync[2] == pin_sync[1])
        line_filt <= pin_sync[2];
    end
  end

  // Receive machine next state
  always_comb
  begin
    next_state    = state;
    next_tick_cnt = tick_cnt;
    next_bit_idx  = bit_idx;
    next_shreg    = shreg;
    next_votes    = votes;
    char_done     = 1'b0;
    stop_bad      = 1'b0;
    if (!rx_on)
    begin
      // Receiver off: park
      next_state    = urad_pkg::ST_IDLE;
      next_tick_cnt = 5'h_00;
    end
    else
      case (state)
        urad_pkg::ST_IDLE:
        begin
          // Low line level starts a character
          next_tick_cnt = 5'h_00;
          next_bit_idx  = 4'h_0;
          if (!line_level)
            next_state = urad_pkg::ST_START;
        end
        urad_pkg::ST_START:
          if (tick)
          begin
            next_tick_cnt = tick_cnt + 5'h_01;
            // Recheck at half a bit; abort quietly if high
            if (next_tick_cnt == (tpb >> 1))
            begin
              next_tick_cnt = 5'h_00;
              next_state    = line_level ? urad_pkg::ST_IDLE : urad_pkg::ST_DATA;
            end
          end
        urad_pkg::ST_DATA, urad_pkg::ST_STOP:
          if (tick)
          begin
            next_tick_cnt = tick_cnt + 5'h_01;
            // Two samples before centre, decision at centre
            if (next_tick_cnt == tpb - 5'h_02 || next_tick_cnt == tpb - 5'h_01)
              next_votes = {votes[0], line_level};
            if (next_tick_cnt == tpb)
            begin
              next_tick_cnt = 5'h_00;
              if (state == urad_pkg::ST_DATA)
              begin
                next_shreg[bit_idx] = voted;
                next_bit_idx        = bit_idx + 4'h_1;
                if (next_bit_idx == (rs_ctrl[urad_pkg::RS_RX9]
                                     ? urad_pkg::BITS_NINE : urad_pkg::BITS_EIGHT))
                  next_state = urad_pkg::ST_STOP;
              end
              else
              begin
                char_done  = 1'b1;
                stop_bad   = !voted;
                next_state = urad_pkg::ST_IDLE;
              end
            end
          end
        default:
          next_state = urad_pkg::ST_IDLE;
      endcase
    // Eight-bit characters carry a clear ninth bit
    if (state == urad_pkg::ST_IDLE)
      next_shreg = 9'h_000;
  end

  // Receive machine registers
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state    <= urad_pkg::ST_IDLE;
      tick_cnt <= 5'h_00;
      bit_idx  <= 4'h_0;
      shreg    <= 9'h_000;
      votes    <= 2'h_0;
    end
    else
    begin
      state    <= next_state;
      tick_cnt <= next_tick_cnt;
      bit_idx  <= next_bit_idx;
      shreg    <= next_shreg;
      votes    <= next_votes;
    end
  end

  // Filter drops characters with a clear ninth bit before any flag moves
  assign discard = rs_ctrl[urad_pkg::RS_ADEN] && !shreg[8];
  assign push    = char_done && !discard && !overrun_flag
                   && fifo_count != urad_pkg::FIFO_DEPTH;
  assign set_ovr = char_done && !discard && !overrun_flag
                   && fifo_count == urad_pkg::FIFO_DEPTH;
  assign pop     = reg_read && reg_addr == urad_pkg::ADDR_RX_DATA && pending;

  // Register group next values
  always_comb
  begin
    next_rs_ctrl    = rs_ctrl;
    next_overrun    = overrun_flag;
    next_evt_status = evt_status;
    next_fifo_count = fifo_count;
    next_rdata      = urad_pkg::ZERO_BYTE;
    if (reg_write && reg_addr == urad_pkg::ADDR_RX_STATUS)
      next_rs_ctrl = reg_wdata & urad_pkg::RS_WMASK;
    // Receive enable low clears overrun; a new overrun wins
    if (!next_rs_ctrl[urad_pkg::RS_CONTINUOUS_RX_ENABLE] || !next_rs_ctrl[urad_pkg::RS_SERIAL_PORT_ENABLE])
      next_overrun = 1'b0;
    if (set_ovr)
      next_overrun = 1'b1;
    // Event bits: clear by writing one, set wins
    if (reg_write && reg_addr == urad_pkg::ADDR_EVT_STATUS)
      next_evt_status = evt_status & ~reg_wdata[urad_pkg::EV_W-1:0];
    if (push)
      next_evt_status[urad_pkg::EV_CHAR] = 1'b1;
    if (push && stop_bad)
      next_evt_status[urad_pkg::EV_FRAME] = 1'b1;
    if (set_ovr)
      next_evt_status[urad_pkg::EV_OVR] = 1'b1;
    next_fifo_count = fifo_count + {1'b0, push} - {1'b0, pop};
    // Port disable flushes the buffer and its error bits
    if (!next_rs_ctrl[urad_pkg::RS_SERIAL_PORT_ENABLE])
      next_fifo_count = 2'h_0;
    if (reg_read)
      case (reg_addr)
        urad_pkg::ADDR_IRQ_FLAGS:
          next_rdata[urad_pkg::IRQ_RX_BIT] = pending && port_on;
        urad_pkg::ADDR_IRQ_ENABLES: next_rdata = irq_enables;
        urad_pkg::ADDR_IRQ_PRIO:    next_rdata = irq_priority;
        urad_pkg::ADDR_RX_STATUS:
        begin
          next_rdata = rs_ctrl;
          next_rdata[urad_pkg::RS_FRAME_ERROR_FLAG] = pending && top[9];
          next_rdata[urad_pkg::RS_OVERRUN_FLAG] = overrun_flag;
          next_rdata[urad_pkg::RS_NINTH_RX_BIT] = pending && top[8];
        end
        urad_pkg::ADDR_RX_DATA:     next_rdata = pending ? top[7:0] : urad_pkg::ZERO_BYTE;
        urad_pkg::ADDR_TX_STATUS:
        begin
          next_rdata = tx_ctrl;
          next_rdata[urad_pkg::TS_TRMT] = 1'b1;
        end
        urad_pkg::ADDR_BAUD_CTRL:
        begin
          next_rdata = baud_ctrl;
          next_rdata[urad_pkg::BC_RCIDL] = state == urad_pkg::ST_IDLE;
        end
        urad_pkg::ADDR_DIV_HIGH:    next_rdata = div_high;
        urad_pkg::ADDR_DIV_LOW:     next_rdata = div_low;
        urad_pkg::ADDR_EVT_STATUS:  next_rdata = {5'h_00, evt_status};
        urad_pkg::ADDR_EVT_MASK:    next_rdata = {5'h_00, evt_mask};
        default:                    next_rdata = urad_pkg::ZERO_BYTE;
      endcase
  end

  // Register group, buffer storage and plain writable registers
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      rs_ctrl      <= urad_pkg::ZERO_BYTE;
      overrun_flag <= 1'b0;
      evt_status   <= 3'h_0;
      evt_mask     <= 3'h_0;
      fifo_count   <= 2'h_0;
      rd_ptr       <= 1'b0;
      wr_ptr       <= 1'b0;
      fifo_mem[0]  <= 10'h_000;
      fifo_mem[1]  <= 10'h_000;
      irq_enables  <= urad_pkg::ZERO_BYTE;
      irq_priority <= urad_pkg::ZERO_BYTE;
      tx_ctrl      <= urad_pkg::ZERO_BYTE;
      baud_ctrl    <= urad_pkg::ZERO_BYTE;
      div_high     <= urad_pkg::ZERO_BYTE;
      div_low      <= urad_pkg::ZERO_BYTE;
      reg_rdata    <= urad_pkg::ZERO_BYTE;
    end
    else
    begin
      rs_ctrl      <= next_rs_ctrl;
      overrun_flag <= next_overrun;
      evt_status   <= next_evt_status;
      fifo_count   <= next_fifo_count;
      reg_rdata    <= next_rdata;
      if (!next_rs_ctrl[urad_pkg::RS_SERIAL_PORT_ENABLE])
      begin
        rd_ptr <= 1'b0;
        wr_ptr <= 1'b0;
      end
      else
      begin
        if (push)
        begin
          fifo_mem[wr_ptr] <= {stop_bad, shreg};
          wr_ptr           <= !wr_ptr;
        end
        if (pop)
          rd_ptr <= !rd_ptr;
      end
      if (reg_write)
        case (reg_addr)
          urad_pkg::ADDR_IRQ_ENABLES: irq_enables  <= reg_wdata & urad_pkg::IRQ_WMASK;
          urad_pkg::ADDR_IRQ_PRIO:    irq_priority <= reg_wdata & urad_pkg::IRQ_WMASK;
          urad_pkg::ADDR_TX_STATUS:   tx_ctrl      <= reg_wdata;
          urad_pkg::ADDR_BAUD_CTRL:   baud_ctrl    <= reg_wdata & urad_pkg::BC_WMASK;
          urad_pkg::ADDR_DIV_HIGH:    div_high     <= reg_wdata;
          urad_pkg::ADDR_DIV_LOW:     div_low      <= reg_wdata;
          urad_pkg::ADDR_EVT_MASK:    evt_mask     <= reg_wdata[urad_pkg::EV_W-1:0];
          default:                    ;
        endcase
    end
  end

  // Pending request only with its enable; priority steers the request level
  assign rx_irq = pending && port_on && irq_enables[urad_pkg::IRQ_RX_BIT];
  assign rx_irq_high_priority = rx_irq && irq_priority[urad_pkg::IRQ_RX_BIT];
  assign irq = |(evt_status & evt_mask);

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  AST_FILTER_NINTH: assert property (push |-> !rs_ctrl[urad_pkg::RS_ADEN] || shreg[8])
    else $error("Filtered push without ninth bit");
  AST_PENDING_SET: assert property (push && !pop && rs_ctrl[urad_pkg::RS_SERIAL_PORT_ENABLE]
    |=> fifo_count == $past(fifo_count) + 2'h_1)
    else $error("Push did not raise buffer count");
  AST_IRQ_GATE: assert property (rx_irq |-> irq_enables[urad_pkg::IRQ_RX_BIT] && fifo_count != 0)
    else $error("Receive request without enable or character");
  AST_OVR_CLEAR: assert property (reg_write && reg_addr == urad_pkg::ADDR_RX_STATUS
    && !reg_wdata[urad_pkg::RS_CONTINUOUS_RX_ENABLE] && !set_ovr |=> !overrun_flag)
    else $error("Overrun not cleared");
  AST_OVR_SET: assert property (char_done && !discard && fifo_count == 2'h_2 && !pop
    && rs_ctrl[urad_pkg::RS_CONTINUOUS_RX_ENABLE] |=> overrun_flag)
    else $error("Third character did not overrun");
  AST_OVR_BLOCK: assert property (overrun_flag |-> !push)
    else $error("Character accepted during overrun");
  AST_DEPTH: assert property (fifo_count <= urad_pkg::FIFO_DEPTH)
    else $error("Buffer count beyond two");
  AST_DISCARD_QUIET: assert property (char_done && discard && !pop
    && rs_ctrl[urad_pkg::RS_SERIAL_PORT_ENABLE] |=> $stable(fifo_count) && $stable(overrun_flag))
    else $error("Discarded character changed state");
  AST_START_MID: assert property (state == urad_pkg::ST_START
    && next_state == urad_pkg::ST_DATA |-> !line_level)
    else $error("Start accepted on high level");

  COV_PUSH: cover property (push);
  COV_OVERRUN: cover property (set_ovr);
  COV_DISCARD: cover property (char_done && discard);
endmodule
`default_nettype wire

/* sim/urad_node_model.sv */
// Purpose: Behavioural transmitting node on the shared serial line
// Assumes: One bit lasts BIT_CLKS clocks; frames start on a one-clock start request
// Notes:   Line idles at the mark level; a faulty stop is short to avoid a false start
`timescale 1ns/100ps
`default_nettype none
module urad_node_model #(
  parameter int BIT_CLKS = 16
) (
  // Clock
  input  wire logic       clock,
  // Frame request
  input  wire logic       start,
  input  wire logic [8:0] data,
  input  wire logic       nine,
  input  wire logic       invert,
  input  wire logic       bad_stop,
  // Line and status
  output var  logic       line,
  output var  logic       busy
);
  // Drive one level for n clocks, changing just after an edge
  task automatic hold(input logic level, input int n);
    line <= level ^ invert;
    repeat (n) @(posedge clock);
  endtask

  // Frame sender: start, data LSB first, stop, then an idle gap
  initial
  begin
    line = 1'b1;
    busy = 1'b0;
    forever
    begin
      @(posedge clock);
      if (start)
      begin
        busy <= 1'b1;
        hold(1'b0, BIT_CLKS);
        for (int i = 0; i < (nine ? 9 : 8); i++)
          hold(data[i], BIT_CLKS);
        // Low only past mid-stop; the start the receiver then sees fails its mid-start check
        if (bad_stop)
          hold(1'b0, BIT_CLKS / 2 + 2);
        hold(1'b1, bad_stop ? BIT_CLKS / 2 - 2 : BIT_CLKS);
        hold(1'b1, BIT_CLKS);
        busy <= 1'b0;
      end
      else
        line <= ~invert;
    end
  end
endmodule
`default_nettype wire

/* sim/urad_rx_bench.sv */
// Purpose: Self-checking bench for the address-detecting serial receiver
// Assumes: Divisor zero with high speed select gives sixteen clocks a bit
// Notes:   Each scenario is one task; all waits are bounded
`timescale 1ns/100ps
`default_nettype none
module urad_rx_bench;
  // Clock, reset and register port
  logic       clock;
  logic       rst;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_write;
  logic       reg_read;
  logic [7:0] reg_rdata;
  // Line and interrupts
  logic       rx_line;
  logic       rx_irq;
  logic       rx_irq_high_priority;
  logic       irq;
  // Partner controls
  logic       tx_start;
  logic [8:0] tx_data;
  logic       tx_invert;
  logic       tx_bad_stop;
  logic       tx_busy;
  // Counters
  int         n_errors;
  int         total_checks;

  urad_rx uut (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .rx_pin(rx_line),
    .rx_irq(rx_irq), .rx_irq_high_priority(rx_irq_high_priority), .irq(irq));

  urad_node_model #(.BIT_CLKS(16)) node (.clock(clock), .start(tx_start), .data(tx_data),
    .nine(1'b1), .invert(tx_invert), .bad_stop(tx_bad_stop), .line(rx_line), .busy(tx_busy));

  // 125 MHz clock
  always #4 clock = ~clock;

  // Verdict and end of run
  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Compare and count
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One-cycle write strobe
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    // Let the write settle before any caller looks at outputs
    #1;
  endtask

  // Read strobe; data sampled in the following cycle only
  task automatic expect_reg(input string name, input logic [3:0] a, input logic [7:0] exp);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 check(name, reg_rdata, exp);
  endtask

  // One frame from the far node, bounded wait for its end
  task automatic send(input logic [8:0] d, input logic bad);
    int i;
    @(posedge clock);
    tx_data     <= d;
    tx_bad_stop <= bad;
    tx_start    <= 1'b1;
    @(posedge clock);
    tx_start <= 1'b0;
    for (i = 0; i < 600; i++)
    begin
      @(posedge clock);
      if (tx_busy === 1'b0)
        break;
    end
    if (i == 600)
    begin
      n_errors++;
      wrap_up();
    end
    #1;
  endtask

  // Reset values, read-only bits and an unmapped index
  task automatic t_reset;
    expect_reg("rx_status", urad_pkg::ADDR_RX_STATUS, 8'h_00);
    wr(4'hF, 8'h_FF);
    expect_reg("unmapped", 4'hF, 8'h_00);
    wr(urad_pkg::ADDR_RX_DATA, 8'h_5A);
    expect_reg("irq_flags", urad_pkg::ADDR_IRQ_FLAGS, 8'h_00);
  endtask

  // Set-up order: divisor, high speed, port with nine bits, interrupts, receive enable last
  task automatic t_setup;
    wr(urad_pkg::ADDR_DIV_HIGH, 8'h_00);
    wr(urad_pkg::ADDR_DIV_LOW, 8'h_00);
    wr(urad_pkg::ADDR_TX_STATUS, 8'h_04);
    wr(urad_pkg::ADDR_RX_STATUS, 8'h_C0);
    wr(urad_pkg::ADDR_IRQ_ENABLES, 8'h_20);
    wr(urad_pkg::ADDR_EVT_MASK, 8'h_07);
    wr(urad_pkg::ADDR_RX_STATUS, 8'h_D0);
    expect_reg("tx_status", urad_pkg::ADDR_TX_STATUS, 8'h_06);
  endtask

  // Plain reception, interrupt gating and the event register
  task automatic t_plain;
    send(9'h1A5, 1'b0);
    check("rx_irq_hp", {7'h0, rx_irq_high_priority}, 8'h_00);
    expect_reg("pending", urad_pkg::ADDR_IRQ_FLAGS, 8'h_20);
    check("rx_irq", {7'h0, rx_irq}, 8'h_01);
    check("irq", {7'h0, irq}, 8'h_01);
    // Priority bit steers the pending request to the high level
    wr(urad_pkg::ADDR_IRQ_PRIO, 8'h_20);
    check("rx_irq_hp_set", {7'h0, rx_irq_high_priority}, 8'h_01);
    expect_reg("status", urad_pkg::ADDR_RX_STATUS, 8'h_D1);
    expect_reg("data", urad_pkg::ADDR_RX_DATA, 8'h_A5);
    check("rx_irq_empty", {7'h0, rx_irq}, 8'h_00);
    wr(urad_pkg::ADDR_EVT_STATUS, 8'h_01);
    check("irq_cleared", {7'h0, irq}, 8'h_00);
    // Enable off: flag only, no request
    wr(urad_pkg::ADDR_IRQ_ENABLES, 8'h_00);
    wr(urad_pkg::ADDR_EVT_MASK, 8'h_00);
    send(9'h13C, 1'b0);
    expect_reg("pending_masked", urad_pkg::ADDR_IRQ_FLAGS, 8'h_20);
    check("rx_irq_masked", {7'h0, rx_irq}, 8'h_00);
    check("irq_masked", {7'h0, irq}, 8'h_00);
    expect_reg("data2", urad_pkg::ADDR_RX_DATA, 8'h_3C);
    wr(urad_pkg::ADDR_IRQ_ENABLES, 8'h_20);
    wr(urad_pkg::ADDR_EVT_MASK, 8'h_07);
    wr(urad_pkg::ADDR_EVT_STATUS, 8'h_07);
  endtask

  // Address filter: drop, match, open for data, re-arm
  task automatic t_filter;
    wr(urad_pkg::ADDR_RX_STATUS, 8'h_D8);
    send(9'h055, 1'b0);
    expect_reg("dropped", urad_pkg::ADDR_IRQ_FLAGS, 8'h_00);
    expect_reg("drop_status", urad_pkg::ADDR_RX_STATUS, 8'h_D8);
    send(9'h142, 1'b0);
    expect_reg("addr_pending", urad_pkg::ADDR_IRQ_FLAGS, 8'h_20);
    expect_reg("addr_status", urad_pkg::ADDR_RX_STATUS, 8'h_D9);
    expect_reg("addr_data", urad_pkg::ADDR_RX_DATA, 8'h_42);
    wr(urad_pkg::ADDR_RX_STATUS, 8'h_D0);
    send(9'h077, 1'b0);
    check("data_irq", {7'h0, rx_irq}, 8'h_01);
    expect_reg("data_status", urad_pkg::ADDR_RX_STATUS, 8'h_D0);
    expect_reg("data_byte", urad_pkg::ADDR_RX_DATA, 8'h_77);
    wr(urad_pkg::ADDR_RX_STATUS, 8'h_D8);
    send(9'h011, 1'b0);
    expect_reg("rearmed", urad_pkg::ADDR_IRQ_FLAGS, 8'h_00);
    wr(urad_pkg::ADDR_RX_STATUS, 8'h_D0);
  endtask

  // Framing status travels with each character
  task automatic t_frame;
    wr(urad_pkg::ADDR_EVT_STATUS, 8'h_07);
    send(9'h1F0, 1'b1);
    send(9'h10F, 1'b0);
    expect_reg("events", urad_pkg::ADDR_EVT_STATUS, 8'h_05);
    expect_reg("frame_error_flag_first", urad_pkg::ADDR_RX_STATUS, 8'h_D5);
    expect_reg("frame_error_flag_data", urad_pkg::ADDR_RX_DATA, 8'h_F0);
    expect_reg("frame_error_flag_second", urad_pkg::ADDR_RX_STATUS, 8'h_D1);
    expect_reg("ok_data", urad_pkg::ADDR_RX_DATA, 8'h_0F);
    wr(urad_pkg::ADDR_EVT_STATUS, 8'h_07);
  endtask

  // Two-deep buffer, overrun lock-out, cleared by receive enable
  task automatic t_overrun;
    send(9'h101, 1'b0);
    send(9'h102, 1'b0);
    send(9'h103, 1'b0);
    send(9'h104, 1'b0);
    expect_reg("overrun", urad_pkg::ADDR_RX_STATUS, 8'h_D3);
    expect_reg("keep1", urad_pkg::ADDR_RX_DATA, 8'h_01);
    expect_reg("keep2", urad_pkg::ADDR_RX_DATA, 8'h_02);
    expect_reg("locked", urad_pkg::ADDR_IRQ_FLAGS, 8'h_00);
    wr(urad_pkg::ADDR_RX_STATUS, 8'h_C0);
    expect_reg("ovr_clear", urad_pkg::ADDR_RX_STATUS, 8'h_C0);
    wr(urad_pkg::ADDR_EVT_STATUS, 8'h_07);
  endtask

  // Inverted line polarity, set while reception is off
  task automatic t_invert;
    tx_invert <= 1'b1;
    wr(urad_pkg::ADDR_BAUD_CTRL, 8'h_20);
    wr(urad_pkg::ADDR_RX_STATUS, 8'h_D0);
    send(9'h1C3, 1'b0);
    expect_reg("inv_status", urad_pkg::ADDR_RX_STATUS, 8'h_D1);
    expect_reg("inv_data", urad_pkg::ADDR_RX_DATA, 8'h_C3);
  endtask

  // Wide divisor with high speed: four ticks a bit, eight-bit characters
  task automatic t_quad;
    wr(urad_pkg::ADDR_RX_STATUS, 8'h_C0);
    tx_invert <= 1'b0;
    wr(urad_pkg::ADDR_BAUD_CTRL, 8'h_08);
    wr(urad_pkg::ADDR_DIV_LOW, 8'h_03);
    // Node sends nine bits; its set ninth bit stands where the stop is due
    wr(urad_pkg::ADDR_RX_STATUS, 8'h_90);
    send(9'h1E1, 1'b0);
    expect_reg("quad_status", urad_pkg::ADDR_RX_STATUS, 8'h_90);
    expect_reg("quad_data", urad_pkg::ADDR_RX_DATA, 8'h_E1);
  endtask

  // Main sequence
  initial
  begin
    clock = 1'b0;
    rst = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 8'h_00;
    reg_write = 1'b0;
    reg_read = 1'b0;
    tx_start = 1'b0;
    tx_data = 9'h000;
    tx_invert = 1'b0;
    tx_bad_stop = 1'b0;
    n_errors = 0;
    total_checks = 0;
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    t_reset();
    t_setup();
    t_plain();
    t_filter();
    t_frame();
    t_overrun();
    t_invert();
    t_quad();
    wrap_up();
  end
endmodule
`default_nettype wire
